// ===== alt_master_select_ack_test.sv
`timescale 1ns/10ps
module alt_master_select_ack_test;
	logic clk, rst, gnt, own, apf, dram, req, rd, slv, attr, bsy, bd, xd;
	logic aoe, act;
	logic [27:0] ra;
	logic [1:0] sz, pt, ty;
	logic [31:0] st;
	logic [7:0] sel;
	logic [3:0] wev;
	amsa_pkg::amsa_cs_cfg_type cfg [8];
	amsa_pkg::amsa_dflt_cfg_type dc;
	int fails, cmp_count;
	int m [10];
	amsa_bus_if bif (.clk(clk));
	amsa_device u_amsa_device (.clk(clk), .rst(rst), .bus(bif),
		.bus_granted_away(gnt), .own_bus(own), .alt_pin_function(apf),
		.dram_hit(dram), .cs_cfg(cfg), .dflt_cfg(dc), .addr_oe(aoe),
		.alt_cycle_active(act));
	amsa_master u_amsa_master (.clk(clk), .rst(rst), .bus(bif), .req(req),
		.req_addr(ra), .req_rd(rd), .req_size(sz), .req_port(pt),
		.req_type(ty), .req_attr(attr), .busy(bsy), .beat_done(bd),
		.xfer_done(xd));
	amsa_asserts u_amsa_asserts (.clk(clk), .rst(rst),
		.rd_wr_n(bif.rd_wr_n), .xfer_start_n(bif.xfer_start_n),
		.ack_drv_n(bif.ack_drv_n), .ack_oe(bif.ack_oe),
		.xfer_ack_n(bif.xfer_ack_n), .cs_n(bif.cs_n), .we_n(bif.we_n));
	// Memory that acks at once; off for auto ranges, else waits end early
	assign bif.slave_ack_n = slv ? &bif.cs_n : 1'b1;
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	function automatic int nb(input logic [1:0] c);
		return c == 0 ? 4 : c == 1 ? 1 : c == 2 ? 2 : 16;
	endfunction
	// Active-low write lanes for a port code; kept at four bits
	function automatic logic [3:0] we_exp(input logic [1:0] p);
		return ~(p == 0 ? 4'hf : p == 2 ? 4'hc : 4'h8);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic rs(input int n);
		rst = 1;
		repeat (n) @(posedge clk);
		#1 rst = 0;
	endtask
	// Indices are counted from the sample that shows the start strobe
	task automatic go(input logic [27:0] a, input int lim, input bit hang);
		logic [31:0] q;
		int s;
		int d;
		int k;
		q = rnd();
		m = '{default: 0};
		sel = 8'h00;
		wev = 4'hf;
		s = -1;
		d = 0;
		ra = a;
		ty = q[1:0];
		attr = q[2];
		req = 1;
		for (int i = 0; i < lim && d < 2; i++) begin
			@(posedge clk);
			#1 req = 0;
			if (!bif.xfer_start_n && s < 0) s = i;
			k = i - s;
			if (d > 0) d++;
			if (xd) d = 1;
			if (s < 0) continue;
			if (!(&bif.cs_n)) begin
				m[0]++;
				m[3] = k;
				sel = sel | ~bif.cs_n;
			end
			if (!bif.xfer_ack_n) begin
				m[1]++;
				if (m[1] == 1) m[2] = k;
				m[3] = k;
			end
			if (bif.ack_oe) m[4]++;
			if (!(&bif.we_n)) begin
				m[5]++;
				wev = bif.we_n;
			end
			if (aoe && act) m[6]++;
			if (bd) m[7]++;
			if (bsy) m[8]++;
			if (act) m[9]++;
		end
		if (!hang && d == 0) begin
			fails++;
			end_of_test();
		end
	endtask
	initial begin
		logic [31:0] r;
		amsa_pkg::amsa_cs_cfg_type cc;
		bit dflt;
		int b, w, g, sp;
		st = 39069;
		{rst, own, apf, dram, req, rd, slv, attr} = '0;
		gnt = 1;
		ra = '0;
		{sz, pt, ty} = '0;
		for (int i = 0; i < 8; i++) begin
			cfg[i] = '0;
			cfg[i].enable = 1'b1;
			cfg[i].base = {5'h00, 3'(i), 20'h00000};
			cfg[i].mask = 28'h00fffff;
			cfg[i].rd_en = 1'b1;
			cfg[i].wr_en = 1'b1;
			cfg[i].ext_master_auto_ack = 1'b1;
		end
		dc = '{1'b0, 1'b1, 4'h0, 2'h0};
		rs(12);
		// Owned bus, bus not granted, DRAM hit, read-disabled range
		for (int c = 0; c < 4; c++) begin
			own = c == 0;
			gnt = c != 1;
			dram = c == 2;
			cfg[0].rd_en = c != 3;
			rd = 1;
			sz = 2'h1;
			go(c == 2 ? 28'h8000000 : 28'h0000000, 12, 1'b1);
			check(m[0] + m[4], 0);
			rs(2);
		end
		own = 1;
		gnt = 0;
		@(posedge clk);
		#1 check(aoe, 1);
		{own, dram} = '0;
		gnt = 1;
		cfg[0].rd_en = 1;
		for (int n = 0; n < 60; n++) begin
			r = rnd();
			dflt = r[2];
			cc = cfg[r[1:0]];
			cc.burst_en = r[3];
			cc.ext_master_auto_ack = dflt | r[16] | r[17];
			cc.wait_count = cc.ext_master_auto_ack ? {2'h0, r[5:4]} : 4'h0;
			cc.addr_setup_en = r[6] & !dflt;
			cc.rd_hold_en = r[7] & !dflt;
			cc.wr_hold_en = r[8] & !dflt;
			cc.port = &r[10:9] ? 2'h0 : r[10:9];
			{cc.mask_super_code, cc.mask_super_data, cc.mask_user_code,
				cc.mask_user_data, cc.mask_cache_inh} = r[22:18];
			rd = r[11];
			sz = r[13:12];
			if (!cc.burst_en && nb(sz) > nb(cc.port)) sz = 2'h1;
			pt = cc.port;
			slv = !cc.ext_master_auto_ack;
			if (dflt) dc = '{cc.burst_en, 1'b1, cc.wait_count, cc.port};
			else cfg[r[1:0]] = cc;
			apf = !dflt && r[14];
			go(dflt ? {4'h8, 4'h0, r[31:12]} :
				{apf ? r[15:12] : 4'h0, 2'h0, r[1:0], r[31:12]}, 250, 1'b0);
			b = cc.burst_en && nb(sz) > nb(pt) ? nb(sz) / nb(pt) : 1;
			w = int'(cc.wait_count);
			g = cc.addr_setup_en + (rd ? cc.rd_hold_en : cc.wr_hold_en);
			sp = b * (w + 1) + (b - 1) * g;
			check(m[1], b);
			check(m[2], 2 + w);
			check(m[3], sp + 1);
			check(m[0], dflt ? 0 : b * (w + 1));
			check(32'(sel), dflt ? 0 : 1 << r[1:0]);
			check(m[4], slv ? 0 : sp + 1);
			check(m[5], !rd && w > 0 && !dflt ? b * (w + 1) : 0);
			check(wev, m[5] == 0 ? 4'hf : we_exp(pt));
			check(m[6], 0);
			check(m[7], b);
			check(m[8], sp + 3);
			check(m[9], sp + 2);
		end
		end_of_test();
	end
endmodule

// ===== amsa_asserts.sv
`timescale 1ns/10ps
module amsa_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic rd_wr_n,
	input wire logic xfer_start_n,
	input wire logic ack_drv_n,
	input wire logic ack_oe,
	input wire logic xfer_ack_n,
	input wire logic [amsa_pkg::NUM_CS-1:0] cs_n,
	input wire logic [amsa_pkg::LANE_W-1:0] we_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_ack_needs_oe: assert property (!ack_drv_n |-> ack_oe)
		else $error("ack low while not driven");
	a_decode_clock_idle: assert property (!xfer_start_n |=> &cs_n)
		else $error("select asserted in second clock");
	a_release_after_negate: assert property
		($fell(ack_oe) |-> $past(ack_drv_n) && $past(&cs_n))
		else $error("ack released before negation");
	// Ack is driven from the third clock on, negated through any waits
	a_oe_rise_acks: assert property
		($rose(ack_oe) |-> !$past(xfer_start_n, 2))
		else $error("ack enabled outside third clock");
	a_write_lane_select: assert property
		(!(&we_n) |-> !(&cs_n) && !rd_wr_n)
		else $error("write strobe without select or write");
	a_one_select: assert property ($onehot0(~cs_n))
		else $error("several selects at once");
	a_start_after_release: assert property (!xfer_start_n |-> !ack_oe)
		else $error("start while ack still driven");
	a_select_waits_ack: assert property
		(!(&cs_n) && xfer_ack_n |=> !(&cs_n))
		else $error("select dropped before ack");
endmodule

// ===== amsa_bus_if.sv
`timescale 1ns/10ps
interface amsa_bus_if (
	input wire logic clk
);
	logic [amsa_pkg::ADDR_W-1:0] addr;
	logic rd_wr_n;
	logic [1:0] xfer_size;
	logic [1:0] xfer_type;
	logic access_mode_attr;
	logic xfer_start_n;
	logic ack_drv_n;
	logic ack_oe;
	logic slave_ack_n;
	logic xfer_ack_n;
	logic [amsa_pkg::NUM_CS-1:0] cs_n;
	logic [amsa_pkg::LANE_W-1:0] we_n;

	// Shared acknowledge wire; slave_ack_n stands for the pulled-up line
	// plus any memory that acknowledges on its own.
	assign xfer_ack_n = ack_oe ? ack_drv_n : slave_ack_n;

	modport device (
		input clk,
		input addr,
		input rd_wr_n,
		input xfer_size,
		input xfer_type,
		input access_mode_attr,
		input xfer_start_n,
		input xfer_ack_n,
		output ack_drv_n,
		output ack_oe,
		output cs_n,
		output we_n
	);

	modport master (
		input clk,
		input xfer_ack_n,
		output addr,
		output rd_wr_n,
		output xfer_size,
		output xfer_type,
		output access_mode_attr,
		output xfer_start_n
	);
endinterface

// ===== amsa_device.sv
// Overview of operation
// RQ1 - Capture address, direction, size on start edge
// RQ2 - Unused upper address pins decode as zero
// RQ3 - Ignore type, mode and range mask bits
// RQ4 - Strobe sequence begins at next clock edge
// RQ5 - Matching enabled range asserts select and writes
// RQ6 - Auto acknowledge drives ack at programmed point
// RQ7 - Never drive address during decoded cycles
// RQ8 - Alternate master supplies address, advances it
// RQ9 - Unmatched address uses default region settings
// RQ10 - Burst when size exceeds port width
// RQ11 - No oversize request to non-burst range
// RQ12 - Second clock decodes and arms the select
// RQ13 - Zero waits: select and ack third clock
// RQ14 - Master waits until ack sampled low
// RQ15 - Negate after last beat, then release ack
// RQ16 - Next start only after ack released
// RQ17 - Setup and hold ignored without burst
// RQ18 - Read burst gaps for setup, read hold
// RQ19 - Write burst gaps for setup, write hold
// RQ20 - Master advances address each narrow beat
// RQ21 - No gaps, no waits: strobes stay asserted
// RQ22 - No write strobes on zero-wait writes
// RQ23 - Ack undriven otherwise; ignore start when owning
`timescale 1ns/10ps
module amsa_device #(
	parameter int NUM_CS = amsa_pkg::NUM_CS
) (
	input wire logic clk,
	input wire logic rst,
	amsa_bus_if.device bus,
	input wire logic bus_granted_away,
	input wire logic own_bus,
	input wire logic alt_pin_function,
	input wire logic dram_hit,
	input amsa_pkg::amsa_cs_cfg_type cs_cfg [NUM_CS],
	input amsa_pkg::amsa_dflt_cfg_type dflt_cfg,
	output logic addr_oe,
	output logic alt_cycle_active
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DECODE,
		ST_ACTIVE,
		ST_GAP,
		ST_DONE
	} amsa_dev_st_type;

	typedef struct packed {
		amsa_dev_st_type st;
		logic [amsa_pkg::ADDR_W-1:0] addr;
		logic rd;
		logic [1:0] size;
		logic hit;
		logic [NUM_CS-1:0] sel_n;
		logic auto_ack;
		logic [amsa_pkg::WAIT_W-1:0] waits;
		logic [amsa_pkg::WAIT_W-1:0] wcnt;
		logic [amsa_pkg::BEAT_W-1:0] beats;
		logic [amsa_pkg::GAP_W-1:0] gap;
		logic [amsa_pkg::GAP_W-1:0] gcnt;
		logic [amsa_pkg::LANE_W-1:0] lanes;
		logic [NUM_CS-1:0] cs_n;
		logic [amsa_pkg::LANE_W-1:0] we_n;
		logic ack_n;
		logic ack_oe;
	} amsa_dev_state_type;

	amsa_dev_state_type s_q;
	amsa_dev_state_type s_d;

	function automatic logic [amsa_pkg::LANE_W-1:0] port_lanes(
		input logic [1:0] p
	);
		port_lanes = (p == amsa_pkg::PORT_32) ? amsa_pkg::LANES_32 :
			(p == amsa_pkg::PORT_16) ? amsa_pkg::LANES_16 :
			amsa_pkg::LANES_8;
	endfunction

	// Starts one beat: select low on a range hit, wait count reloaded, ack only when
	// no waits are programmed.
	function automatic amsa_dev_state_type begin_beat(
		input amsa_dev_state_type v
	);
		amsa_dev_state_type r;
		r = v;
		r.st = ST_ACTIVE;
		r.cs_n = v.hit ? v.sel_n : '1; // RQ5
		r.wcnt = v.waits;
		r.ack_n = !(v.auto_ack && v.waits == '0); // RQ13
		r.ack_oe = v.auto_ack; // RQ6
		// Writes only strobe when a wait gives the memory time to latch
		if (v.hit && !v.rd && v.waits != '0) begin // RQ22
			r.we_n = ~v.lanes; // RQ5
		end else begin
			r.we_n = '1;
		end
		return r;
	endfunction

	function automatic amsa_dev_state_type end_cycle(
		input amsa_dev_state_type v
	);
		amsa_dev_state_type r;
		r = v;
		r.cs_n = '1;
		r.we_n = '1;
		r.ack_n = 1'b1;
		return r;
	endfunction

	logic match_any;
	logic [$clog2(NUM_CS)-1:0] match_idx;
	logic [amsa_pkg::ADDR_W-1:0] cap_addr;

	// Lowest-numbered range wins when ranges overlap. Only enable, base
	// and mask take part; the mode and cache mask bits do not.
	always_comb begin
		match_any = 1'b0;
		match_idx = '0;
		for (int i = NUM_CS - 1; i >= 0; i--) begin
			if (cs_cfg[i].enable &&
				((s_q.addr ^ cs_cfg[i].base) & ~cs_cfg[i].mask) == '0) begin // RQ3
				match_any = 1'b1;
				match_idx = i[$clog2(NUM_CS)-1:0];
			end
		end
	end

	always_comb begin
		cap_addr = bus.addr;
		if (alt_pin_function) begin
			cap_addr[amsa_pkg::ADDR_W-1:amsa_pkg::UPPER_LSB] =
				amsa_pkg::UPPER_ZERO; // RQ2
		end
	end

	always_comb begin
		logic [1:0] port;
		logic burst_en;
		logic [amsa_pkg::BEAT_W-1:0] sb;
		logic [amsa_pkg::BEAT_W-1:0] pb;
		logic dir_ok;
		logic beat_end;
		port = dflt_cfg.port;
		burst_en = dflt_cfg.burst_en;
		sb = '0;
		pb = '0;
		dir_ok = 1'b0;
		beat_end = 1'b0;
		s_d = s_q;
		unique case (s_q.st)
			ST_IDLE: begin
				s_d.ack_oe = 1'b0; // RQ23
				// Transfer type and mode inputs are never looked at
				if (bus_granted_away && !own_bus &&
					!bus.xfer_start_n) begin // RQ23
					s_d.addr = cap_addr; // RQ1
					s_d.rd = bus.rd_wr_n; // RQ1
					s_d.size = bus.xfer_size; // RQ1
					s_d.st = ST_DECODE;
				end
			end
			ST_DECODE: begin
				s_d.sel_n = '1;
				if (match_any) begin // RQ12
					dir_ok = s_q.rd ? cs_cfg[match_idx].rd_en :
						cs_cfg[match_idx].wr_en;
					port = cs_cfg[match_idx].port;
					burst_en = cs_cfg[match_idx].burst_en;
					s_d.hit = dir_ok;
					s_d.sel_n[match_idx] = 1'b0;
					s_d.auto_ack = dir_ok &&
						cs_cfg[match_idx].ext_master_auto_ack;
					s_d.waits = cs_cfg[match_idx].wait_count;
					s_d.gap = {1'b0, cs_cfg[match_idx].addr_setup_en} +
						{1'b0, s_q.rd ? cs_cfg[match_idx].rd_hold_en :
						cs_cfg[match_idx].wr_hold_en}; // RQ18 RQ19
				end else begin // RQ9
					dir_ok = !dram_hit;
					s_d.hit = 1'b0;
					s_d.auto_ack = !dram_hit && dflt_cfg.ext_master_auto_ack;
					s_d.waits = dflt_cfg.wait_count;
					s_d.gap = '0;
				end
				sb = amsa_pkg::size_bytes(s_q.size);
				pb = amsa_pkg::BEAT_W'(5'h01 << amsa_pkg::port_shift(port));
				if (burst_en && sb > pb) begin // RQ10
					s_d.beats = sb >> amsa_pkg::port_shift(port);
				end else begin
					s_d.beats = 5'h01; // RQ17
				end
				s_d.lanes = port_lanes(port);
				// A range closed to this direction gets no strobes at all
				if (dir_ok) begin
					s_d = begin_beat(s_d); // RQ4
				end else begin
					s_d.st = ST_IDLE;
				end
			end
			ST_ACTIVE: begin
				// Without auto ack the beat ends on the memory's own ack
				beat_end = s_q.auto_ack ? !s_q.ack_n : !bus.xfer_ack_n;
				if (beat_end) begin
					s_d.beats = s_q.beats - 5'h01;
					if (s_q.beats == 5'h01) begin
						s_d = end_cycle(s_d); // RQ15
						s_d.st = ST_DONE;
					end else if (s_q.gap != '0) begin
						s_d = end_cycle(s_d); // RQ18 RQ19
						s_d.gcnt = s_q.gap;
						s_d.st = ST_GAP;
					end else begin
						s_d = begin_beat(s_d); // RQ21
					end
				end else if (s_q.wcnt != '0) begin
					s_d.wcnt = s_q.wcnt - 4'h1;
					if (s_q.wcnt == 4'h1 && s_q.auto_ack) begin
						s_d.ack_n = 1'b0; // RQ9 RQ6
					end
				end
			end
			ST_GAP: begin
				s_d.gcnt = s_q.gcnt - 2'h1;
				if (s_q.gcnt == 2'h1) begin
					s_d = begin_beat(s_d); // RQ18 RQ19
				end
			end
			ST_DONE: begin
				s_d.ack_oe = 1'b0; // RQ15
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '{st: ST_IDLE, sel_n: '1, cs_n: '1, we_n: '1,
				ack_n: 1'b1, beats: 5'h01, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.cs_n = s_q.cs_n;
	assign bus.we_n = s_q.we_n;
	assign bus.ack_drv_n = s_q.ack_n;
	assign bus.ack_oe = s_q.ack_oe; // RQ23
	assign alt_cycle_active = s_q.st != ST_IDLE;
	// Address stays off the pins for the whole alternate cycle
	assign addr_oe = own_bus && !bus_granted_away &&
		s_q.st == ST_IDLE; // RQ7

endmodule

// ===== amsa_master.sv
`timescale 1ns/10ps
module amsa_master (
	input wire logic clk,
	input wire logic rst,
	amsa_bus_if.master bus,
	input wire logic req,
	input wire logic [amsa_pkg::ADDR_W-1:0] req_addr,
	input wire logic req_rd,
	input wire logic [1:0] req_size,
	input wire logic [1:0] req_port,
	input wire logic [1:0] req_type,
	input wire logic req_attr,
	output logic busy,
	output logic beat_done,
	output logic xfer_done
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_WAIT,
		ST_TAIL
	} amsa_mst_st_type;

	typedef struct packed {
		amsa_mst_st_type st;
		logic [amsa_pkg::ADDR_W-1:0] addr;
		logic rd;
		logic [1:0] size;
		logic [1:0] ttype;
		logic attr;
		logic start_n;
		logic [amsa_pkg::BEAT_W-1:0] left;
		logic [amsa_pkg::BEAT_W-1:0] step;
		logic beat_done;
		logic xfer_done;
	} amsa_mst_state_type;

	amsa_mst_state_type m_q;
	amsa_mst_state_type m_d;

	always_comb begin
		logic [amsa_pkg::BEAT_W-1:0] sb;
		logic [amsa_pkg::BEAT_W-1:0] pb;
		sb = amsa_pkg::size_bytes(req_size);
		pb = amsa_pkg::BEAT_W'(5'h01 << amsa_pkg::port_shift(req_port));
		m_d = m_q;
		m_d.beat_done = 1'b0;
		m_d.xfer_done = 1'b0;
		unique case (m_q.st)
			ST_IDLE: begin
				// Reached only once the ack line is released
				if (req) begin // RQ16
					m_d.addr = req_addr;
					m_d.rd = req_rd;
					m_d.size = req_size;
					m_d.ttype = req_type;
					m_d.attr = req_attr;
					m_d.left = sb;
					// Caller must not ask oversize of a non-burst range
					m_d.step = (pb < sb) ? pb : sb; // RQ11
					m_d.start_n = 1'b0;
					m_d.st = ST_START;
				end
			end
			ST_START: begin
				m_d.start_n = 1'b1;
				m_d.st = ST_WAIT;
			end
			ST_WAIT: begin
				if (!bus.xfer_ack_n) begin // RQ14
					m_d.beat_done = 1'b1;
					m_d.left = m_q.left - m_q.step;
					if (m_q.left <= m_q.step) begin
						m_d.xfer_done = 1'b1;
						m_d.st = ST_TAIL;
					end else begin
						m_d.addr = m_q.addr +
							amsa_pkg::ADDR_W'(m_q.step); // RQ8 RQ20
					end
				end
			end
			ST_TAIL: begin
				m_d.st = ST_IDLE; // RQ16
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			m_q <= '{st: ST_IDLE, start_n: 1'b1, rd: 1'b1, default: '0};
		end else begin
			m_q <= m_d;
		end
	end

	assign bus.addr = m_q.addr;
	assign bus.rd_wr_n = m_q.rd;
	assign bus.xfer_size = m_q.size;
	assign bus.xfer_type = m_q.ttype;
	assign bus.access_mode_attr = m_q.attr;
	assign bus.xfer_start_n = m_q.start_n;
	assign busy = m_q.st != ST_IDLE;
	assign beat_done = m_q.beat_done;
	assign xfer_done = m_q.xfer_done;

endmodule

// ===== amsa_pkg.sv
package amsa_pkg;

	localparam int ADDR_W = 28;
	localparam int NUM_CS = 8;
	localparam int WAIT_W = 4;
	localparam int BEAT_W = 5;
	localparam int GAP_W = 2;
	localparam int LANE_W = 4;
	localparam int UPPER_LSB = 24;
	localparam logic [3:0] UPPER_ZERO = 4'h0;

	// Transfer size codes
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;

	// Port width codes
	localparam logic [1:0] PORT_32 = 2'h0;
	localparam logic [1:0] PORT_8 = 2'h1;
	localparam logic [1:0] PORT_16 = 2'h2;

	// Byte lanes per port width, bit 3 is the top lane
	localparam logic [3:0] LANES_32 = 4'hf;
	localparam logic [3:0] LANES_16 = 4'hc;
	localparam logic [3:0] LANES_8 = 4'h8;

	typedef struct packed {
		logic enable;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] mask;
		logic rd_en;
		logic wr_en;
		logic burst_en;
		logic ext_master_auto_ack;
		logic [WAIT_W-1:0] wait_count;
		logic addr_setup_en;
		logic rd_hold_en;
		logic wr_hold_en;
		logic [1:0] port;
		logic mask_super_code;
		logic mask_super_data;
		logic mask_user_code;
		logic mask_user_data;
		logic mask_cache_inh;
	} amsa_cs_cfg_type;

	typedef struct packed {
		logic burst_en;
		logic ext_master_auto_ack;
		logic [WAIT_W-1:0] wait_count;
		logic [1:0] port;
	} amsa_dflt_cfg_type;

	function automatic logic [BEAT_W-1:0] size_bytes(input logic [1:0] s);
		unique case (s)
			SIZE_LONG: size_bytes = 5'h04;
			SIZE_BYTE: size_bytes = 5'h01;
			SIZE_WORD: size_bytes = 5'h02;
			SIZE_LINE: size_bytes = 5'h10;
		endcase
	endfunction

	function automatic logic [1:0] port_shift(input logic [1:0] p);
		port_shift = (p == PORT_32) ? 2'h2 : (p == PORT_16) ? 2'h1 : 2'h0;
	endfunction

endpackage
